/* File: src/access_guard_pkg.sv */
/*
 Shared constants and carrier types for the peripheral write-protect guard.
 Assumes a 32-bit peripheral bridge with byte strobes in front of the guard.
*/
package access_guard_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 4;
	localparam int STRB_W = 4;
	localparam int PERIPH_IDX_W = 5;
	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_PROTECT_CLEAR = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_PROTECT_SET = 4'h4;
	// Reset value of the shared protect vector
	localparam logic [DATA_W-1:0] PROTECT_RESET = 32'h0000_0000;
	// Protect bit positions of the first instance
	localparam int BIT_POWER_MANAGER = 1;
	localparam int BIT_SYSTEM_CONTROL = 2;
	localparam int BIT_CLOCK_GENERATOR = 3;
	localparam int BIT_WATCHDOG_UNIT = 4;
	localparam int BIT_REAL_TIME_COUNTER = 5;
	localparam int BIT_EXTERNAL_IRQ_UNIT = 6;
	localparam logic [DATA_W-1:0] IMPLEMENTED_MASK_0 = 32'h0000_007e;
	// Instance that starts with its bus clock stopped
	localparam int GATED_AT_RESET_INSTANCE = 2;

	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [STRB_W-1:0] strb;
	} reg_req_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic debugger;
		logic [PERIPH_IDX_W-1:0] periph;
	} guard_req_t;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_SETUP = 2'b01,
		BUS_ACCESS = 2'b10
	} bus_state_t;
endpackage

/* File: src/access_guard.sv */
/*
 Write-protect guard for the peripherals of one bridge: protect vector with
 paired clear/set registers, a register slave port and a per-access check.
 Assumes the bridge presents a two-phase register access (setup, then access)
 and forwards each peripheral access to the check port one per cycle.
*/
// How it works
// - One guard per bridge, covers its peripherals.
// - Bus clock gated; third instance starts off.
// - Keeps guarding whenever its clock runs and clk_en is high.
// - Debugger writes bypass protection.
// - Clear-register one clears shared protect bit.
// - Set-register one sets shared protect bit.
// - Zero bits leave protect bits unchanged.
// - Both registers read same protect vector.
// - Protected write dropped, access error returned.
// - Setting already-protected bit returns error.
// - Clearing already-unprotected bit returns error.
// - Byte, halfword and word accesses supported.
// - Registers reached through bridge, error carried back.
`timescale 1ns/1ps
module access_guard #(
	parameter int INSTANCE = 0,
	parameter logic [31:0] IMPLEMENTED_MASK = access_guard_pkg::IMPLEMENTED_MASK_0
) (
	// Clock, reset, enable
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	// Bus clock request from the power manager
	input wire logic guard_bus_clock,
	// Register port
	input wire access_guard_pkg::reg_req_t reg_req,
	output logic [access_guard_pkg::DATA_W-1:0] reg_rdata,
	output logic reg_ready,
	output logic reg_error,
	// Peripheral access check
	input wire access_guard_pkg::guard_req_t guard_req,
	output logic guard_pass,
	output logic guard_error,
	// Protect state
	output logic [access_guard_pkg::DATA_W-1:0] protect_state,
	output logic clock_running
);
	localparam logic CLOCK_AT_RESET = (INSTANCE != access_guard_pkg::GATED_AT_RESET_INSTANCE);

	logic [access_guard_pkg::DATA_W-1:0] protect;
	logic clock_on;
	access_guard_pkg::bus_state_t bus_state;
	access_guard_pkg::bus_state_t next_bus_state;

	wire logic active = clk_en & clock_on;
	wire logic hit_clear = (reg_req.addr == access_guard_pkg::OFS_PROTECT_CLEAR);
	wire logic hit_set = (reg_req.addr == access_guard_pkg::OFS_PROTECT_SET);
	wire logic mapped = hit_clear | hit_set;
	// Byte lanes expanded to a bit mask
	wire logic [31:0] lane_mask = {{8{reg_req.strb[3]}}, {8{reg_req.strb[2]}},
		{8{reg_req.strb[1]}}, {8{reg_req.strb[0]}}};
	wire logic [31:0] write_ones = reg_req.wdata & lane_mask & IMPLEMENTED_MASK;
	wire logic double_set = hit_set & (|(write_ones & protect));
	wire logic double_clear = hit_clear & (|(write_ones & ~protect));
	wire logic setup_phase = reg_req.sel & ~reg_req.enable;
	wire logic take_setup = (bus_state == access_guard_pkg::BUS_IDLE) & setup_phase;
	wire logic commit = reg_req.sel & reg_req.enable & reg_ready & reg_req.write & mapped;
	wire logic [31:0] next_protect = hit_set ? (protect | write_ones) : (protect & ~write_ones);
	wire logic answer_error = ~mapped | (reg_req.write & (double_set | double_clear));
	wire logic [31:0] answer_data = (mapped & ~reg_req.write) ? (protect & IMPLEMENTED_MASK) : 32'h0000_0000;
	wire logic blocked = guard_req.valid & guard_req.write & ~guard_req.debugger
		& protect[guard_req.periph];

	always_comb begin
		case (bus_state)
			access_guard_pkg::BUS_IDLE: next_bus_state = setup_phase ? access_guard_pkg::BUS_SETUP
				: access_guard_pkg::BUS_IDLE;
			access_guard_pkg::BUS_SETUP: next_bus_state = access_guard_pkg::BUS_ACCESS;
			access_guard_pkg::BUS_ACCESS: next_bus_state = access_guard_pkg::BUS_IDLE;
			default: next_bus_state = access_guard_pkg::BUS_IDLE;
		endcase
	end

	// Bus clock gate follows the power manager; third instance resets stopped
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			clock_on <= CLOCK_AT_RESET;
			clock_running <= CLOCK_AT_RESET;
		end else if (clk_en) begin
			clock_on <= guard_bus_clock;
			clock_running <= guard_bus_clock;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bus_state <= access_guard_pkg::BUS_IDLE;
		end else if (active) begin
			bus_state <= next_bus_state;
		end
	end

	// Answer taken at setup; ready and error stand one cycle, data until the next answer
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reg_ready <= 1'b0;
			reg_error <= 1'b0;
			reg_rdata <= 32'h0000_0000;
		end else if (active) begin
			reg_ready <= take_setup;
			reg_error <= take_setup & answer_error;
			if (take_setup) begin
				reg_rdata <= answer_data;
			end
		end
	end

	// Shared protect vector; write still lands when a double operation is flagged
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			protect <= access_guard_pkg::PROTECT_RESET;
			protect_state <= access_guard_pkg::PROTECT_RESET;
		end else if (active) begin
			if (commit) begin
				protect <= next_protect;
				protect_state <= next_protect;
			end
		end
	end

	// Check runs only while clk_en is high and the bus clock gate is on; otherwise it holds its answer
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			guard_pass <= 1'b0;
			guard_error <= 1'b0;
		end else if (active) begin
			guard_pass <= guard_req.valid & ~blocked;
			guard_error <= blocked;
		end
	end

	AST_BLOCKED_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
		active & guard_req.valid & guard_req.write & ~guard_req.debugger & protect[guard_req.periph]
		|=> guard_error & ~guard_pass)
		else $error("Protected write not refused");
	AST_DEBUG_BYPASS: assert property (@(posedge sys_clk) disable iff (rst)
		active & guard_req.valid & guard_req.debugger |=> guard_pass & ~guard_error)
		else $error("Debugger write was refused");
	AST_SET_BITS: assert property (@(posedge sys_clk) disable iff (rst)
		active & commit & hit_set |=> ((protect & $past(write_ones)) == $past(write_ones)))
		else $error("Set write did not set protect bits");
	AST_CLEAR_BITS: assert property (@(posedge sys_clk) disable iff (rst)
		active & commit & hit_clear |=> ((protect & $past(write_ones)) == 32'h0000_0000))
		else $error("Clear write did not clear protect bits");
	AST_ZERO_KEEPS: assert property (@(posedge sys_clk) disable iff (rst)
		active & commit |=> ((protect & ~$past(write_ones)) == ($past(protect) & ~$past(write_ones))))
		else $error("Zero bits changed protect state");
	AST_SAME_READ: assert property (@(posedge sys_clk) disable iff (rst)
		active & (bus_state == access_guard_pkg::BUS_IDLE) & setup_phase & mapped & ~reg_req.write
		|=> reg_ready & (reg_rdata == (protect & IMPLEMENTED_MASK)))
		else $error("Read data differs from protect vector");
	AST_DOUBLE_SET: assert property (@(posedge sys_clk) disable iff (rst)
		active & (bus_state == access_guard_pkg::BUS_IDLE) & setup_phase & reg_req.write & double_set
		|=> reg_ready & reg_error)
		else $error("Double protect gave no error");
	AST_DOUBLE_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
		active & (bus_state == access_guard_pkg::BUS_IDLE) & setup_phase & reg_req.write & double_clear
		|=> reg_ready & reg_error)
		else $error("Double unprotect gave no error");
	AST_UNUSED_ZERO: assert property (@(posedge sys_clk) disable iff (rst)
		(protect & ~IMPLEMENTED_MASK) == 32'h0000_0000)
		else $error("Unimplemented protect bit set");
	AST_READY_ONE_CYCLE: assert property (@(posedge sys_clk) disable iff (rst)
		reg_ready & active |=> ~reg_ready)
		else $error("Ready held longer than one cycle");
	AST_CLOCK_GATE: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en & ~guard_bus_clock |=> ~clock_running)
		else $error("Bus clock gate ignored power manager");

	// Register port answers
	AST_READY_AFTER_SETUP: assert property (@(posedge sys_clk) disable iff (rst)
		active & take_setup
		|=> reg_ready)
		else $error("No answer after setup");
	AST_READY_ONLY_ASKED: assert property (@(posedge sys_clk) disable iff (rst)
		active & ~take_setup
		|=> ~reg_ready)
		else $error("Answer without setup");
	AST_ERROR_NEEDS_READY: assert property (@(posedge sys_clk) disable iff (rst)
		reg_error |-> reg_ready)
		else $error("Error shown without ready");
	AST_ERROR_ONE_CYCLE: assert property (@(posedge sys_clk) disable iff (rst)
		reg_error & active
		|=> ~reg_error)
		else $error("Error held longer than one cycle");
	AST_UNMAPPED_ERROR: assert property (@(posedge sys_clk) disable iff (rst)
		active & take_setup & ~mapped
		|=> reg_ready & reg_error)
		else $error("Unmapped access gave no error");
	AST_UNMAPPED_KEEPS: assert property (@(posedge sys_clk) disable iff (rst)
		active & reg_req.sel & reg_req.enable & ~mapped
		|=> (protect == $past(protect)))
		else $error("Unmapped access changed protect state");
	AST_CLEAN_WRITE_OK: assert property (@(posedge sys_clk) disable iff (rst)
		active & take_setup & mapped & reg_req.write & ~double_set & ~double_clear
		|=> reg_ready & ~reg_error)
		else $error("Clean write gave an error");
	AST_READ_NO_ERROR: assert property (@(posedge sys_clk) disable iff (rst)
		active & take_setup & mapped & ~reg_req.write
		|=> reg_ready & ~reg_error)
		else $error("Register read gave an error");
	AST_RDATA_HOLDS: assert property (@(posedge sys_clk) disable iff (rst)
		~(active & take_setup)
		|=> $stable(reg_rdata))
		else $error("Read data moved between answers");
	AST_RDATA_MASKED: assert property (@(posedge sys_clk) disable iff (rst)
		(reg_rdata & ~IMPLEMENTED_MASK) == 32'h0000_0000)
		else $error("Unimplemented bit read as one");
	AST_WRITE_RDATA_ZERO: assert property (@(posedge sys_clk) disable iff (rst)
		active & take_setup & reg_req.write
		|=> (reg_rdata == 32'h0000_0000))
		else $error("Write answer carried data");
	AST_READ_KEEPS: assert property (@(posedge sys_clk) disable iff (rst)
		active & reg_req.sel & ~reg_req.write
		|=> (protect == $past(protect)))
		else $error("Read changed protect state");

	// Access sequence
	AST_IDLE_TO_SETUP: assert property (@(posedge sys_clk) disable iff (rst)
		active & take_setup
		|=> (bus_state == access_guard_pkg::BUS_SETUP))
		else $error("Setup not taken");
	AST_IDLE_WAITS: assert property (@(posedge sys_clk) disable iff (rst)
		active & (bus_state == access_guard_pkg::BUS_IDLE) & ~setup_phase
		|=> (bus_state == access_guard_pkg::BUS_IDLE))
		else $error("Left idle without setup");
	AST_SETUP_TO_ACCESS: assert property (@(posedge sys_clk) disable iff (rst)
		active & (bus_state == access_guard_pkg::BUS_SETUP)
		|=> (bus_state == access_guard_pkg::BUS_ACCESS))
		else $error("Setup did not move to access");
	AST_ACCESS_TO_IDLE: assert property (@(posedge sys_clk) disable iff (rst)
		active & (bus_state == access_guard_pkg::BUS_ACCESS)
		|=> (bus_state == access_guard_pkg::BUS_IDLE))
		else $error("Access did not return to idle");
	AST_STATE_LEGAL: assert property (@(posedge sys_clk) disable iff (rst)
		bus_state inside {access_guard_pkg::BUS_IDLE, access_guard_pkg::BUS_SETUP, access_guard_pkg::BUS_ACCESS})
		else $error("Bus state out of range");
	AST_COMMIT_IN_SETUP: assert property (@(posedge sys_clk) disable iff (rst)
		active & commit
		|-> (bus_state == access_guard_pkg::BUS_SETUP))
		else $error("Write committed outside its access");
	AST_READY_IN_SETUP: assert property (@(posedge sys_clk) disable iff (rst)
		reg_ready |-> (bus_state == access_guard_pkg::BUS_SETUP))
		else $error("Ready outside the access cycle");

	// Protect vector
	AST_SET_ONLY_SETS: assert property (@(posedge sys_clk) disable iff (rst)
		active & commit & hit_set
		|=> ((protect & $past(protect)) == $past(protect)))
		else $error("Set write cleared a protect bit");
	AST_CLEAR_ONLY_CLEARS: assert property (@(posedge sys_clk) disable iff (rst)
		active & commit & hit_clear
		|=> ((protect & ~$past(protect)) == 32'h0000_0000))
		else $error("Clear write set a protect bit");
	AST_LANE_OFF_KEEPS: assert property (@(posedge sys_clk) disable iff (rst)
		active & commit
		|=> (((protect ^ $past(protect)) & ~$past(lane_mask)) == 32'h0000_0000))
		else $error("Disabled byte lane changed protect state");
	AST_NO_COMMIT_KEEPS: assert property (@(posedge sys_clk) disable iff (rst)
		~(active & commit)
		|=> (protect == $past(protect)))
		else $error("Protect state changed without a write");
	AST_STATE_COPY: assert property (@(posedge sys_clk) disable iff (rst)
		protect_state == protect)
		else $error("Protect state output differs from vector");

	// Check port
	AST_ONE_ANSWER: assert property (@(posedge sys_clk) disable iff (rst)
		active & guard_req.valid
		|=> guard_pass | guard_error)
		else $error("Peripheral access got no answer");
	AST_READ_PASSES: assert property (@(posedge sys_clk) disable iff (rst)
		active & guard_req.valid & ~guard_req.write
		|=> guard_pass & ~guard_error)
		else $error("Peripheral read was refused");
	AST_OPEN_PASSES: assert property (@(posedge sys_clk) disable iff (rst)
		active & guard_req.valid & ~protect[guard_req.periph]
		|=> guard_pass & ~guard_error)
		else $error("Unprotected access was refused");
	AST_NO_REQ_QUIET: assert property (@(posedge sys_clk) disable iff (rst)
		active & ~guard_req.valid
		|=> ~guard_pass & ~guard_error)
		else $error("Answer without a peripheral access");
	AST_PASS_OR_ERROR: assert property (@(posedge sys_clk) disable iff (rst)
		~(guard_pass & guard_error))
		else $error("Pass and error shown together");

	// Clock gate and freeze
	AST_CLOCK_GATE_ON: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en & guard_bus_clock
		|=> clock_running)
		else $error("Bus clock gate did not open");
	AST_CLOCK_COPY: assert property (@(posedge sys_clk) disable iff (rst)
		clock_running == clock_on)
		else $error("Clock running output differs from gate");
	AST_CLOCK_FROZEN: assert property (@(posedge sys_clk) disable iff (rst)
		~clk_en
		|=> $stable(clock_running) & $stable(clock_on))
		else $error("Bus clock gate moved while frozen");
	AST_FREEZE_VECTOR: assert property (@(posedge sys_clk) disable iff (rst)
		~active
		|=> $stable(protect))
		else $error("Protect vector moved while frozen");
	AST_FREEZE_BUS: assert property (@(posedge sys_clk) disable iff (rst)
		~active
		|=> $stable(bus_state))
		else $error("Bus state moved while frozen");
	AST_FREEZE_ANSWER: assert property (@(posedge sys_clk) disable iff (rst)
		~active
		|=> $stable(reg_ready) & $stable(reg_error) & $stable(reg_rdata))
		else $error("Register answer moved while frozen");
	AST_FREEZE_CHECK: assert property (@(posedge sys_clk) disable iff (rst)
		~active
		|=> $stable(guard_pass) & $stable(guard_error))
		else $error("Check answer moved while frozen");
	AST_FREEZE_STATE_OUT: assert property (@(posedge sys_clk) disable iff (rst)
		~active
		|=> $stable(protect_state))
		else $error("Protect state output moved while frozen");
endmodule

/* File: testbench/bus_master_model.sv */
/* Bus master model: processor or debugger behind the bridge.
 Assumes answers come one cycle after setup and one cycle after a check. */
`timescale 1ns/1ps
module bus_master_model (
	// Clock
	input wire logic sys_clk,
	// Register side
	output access_guard_pkg::reg_req_t reg_req,
	input wire logic [31:0] reg_rdata,
	input wire logic reg_ready,
	input wire logic reg_error,
	// Check side
	output access_guard_pkg::guard_req_t guard_req,
	input wire logic guard_pass,
	input wire logic guard_error
);
	initial begin
		reg_req = '0;
		guard_req = '0;
	end
	// Setup then access, held until ready is sampled or four cycles pass
	task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		@(posedge sys_clk);
		#1 reg_req = '{sel: 1'b1, enable: 1'b0, write: wr, addr: a, wdata: d, strb: s};
		@(posedge sys_clk);
		#1 reg_req.enable = 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (reg_ready !== 1'b1 && n < 4);
		rd = reg_rdata;
		er = reg_error;
		if (reg_ready !== 1'b1) begin
			rd = 'x;
			er = 1'bx;
		end
		#1 reg_req.sel = 1'b0;
		reg_req.enable = 1'b0;
		reg_req.wdata = ~d;
	endtask
	// One peripheral access offered for checking
	task automatic probe(input logic wr, input logic dbg, input logic [4:0] p, output logic [1:0] ans);
		@(posedge sys_clk);
		#1 guard_req = '{valid: 1'b1, write: wr, debugger: dbg, periph: p};
		@(posedge sys_clk);
		#1 guard_req.valid = 1'b0;
		@(posedge sys_clk);
		ans = {guard_error, guard_pass};
	endtask
endmodule

/* File: testbench/access_guard_tb.sv */
/* Self-checking bench for the write-protect guard, first instance.
 Assumes the bus master model drives both request ports. */
`timescale 1ns/1ps
module access_guard_tb;
	logic sys_clk, rst, guard_bus_clock, reg_ready, reg_error, guard_pass, guard_error, clock_running, er;
	logic [31:0] reg_rdata, protect_state, rd, expv;
	logic [1:0] ans;
	logic clk_en;
	access_guard_pkg::reg_req_t reg_req;
	access_guard_pkg::guard_req_t guard_req;
	int err_total, check_count, cycles;
	access_guard u_access_guard (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .guard_bus_clock(guard_bus_clock),
		.reg_req(reg_req), .reg_rdata(reg_rdata), .reg_ready(reg_ready), .reg_error(reg_error),
		.guard_req(guard_req), .guard_pass(guard_pass), .guard_error(guard_error),
		.protect_state(protect_state), .clock_running(clock_running));
	bus_master_model u_bus_master_model (.sys_clk(sys_clk), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.reg_ready(reg_ready), .reg_error(reg_error), .guard_req(guard_req), .guard_pass(guard_pass),
		.guard_error(guard_error));
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Write, then read back through the other offset
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic e);
		u_bus_master_model.xfer(1'b1, a, d, s, rd, er);
		check("write error", {31'h0, e}, {31'h0, er});
		u_bus_master_model.xfer(1'b0, (a == 4'h4) ? 4'h0 : 4'h4, 32'h0, 4'hf, rd, er);
		check("read back", expv, rd);
		check("protect_state", expv, protect_state);
	endtask
	task automatic pr(input logic w, input logic dbg, input logic [4:0] p, input logic [1:0] e);
		u_bus_master_model.probe(w, dbg, p, ans);
		check("check answer", {30'h0, e}, {30'h0, ans});
	endtask
	task automatic t_freeze();
		@(posedge sys_clk);
		#1 clk_en = 1'b0;
		guard_bus_clock = 1'b0;
		pr(1'b1, 1'b0, 5'd2, 2'b00);
		check("clock_running", 32'h1, {31'h0, clock_running});
		#1 clk_en = 1'b1;
		guard_bus_clock = 1'b1;
		pr(1'b1, 1'b0, 5'd2, 2'b10);
	endtask
	task automatic t_rerst();
		@(posedge sys_clk);
		#1 rst = 1'b1;
		@(posedge sys_clk);
		#1 rst = 1'b0;
		check("protect_state", 32'h0, protect_state);
		check("clock_running", 32'h1, {31'h0, clock_running});
		expv = 32'h40;
		wr(4'h4, 32'h0000_4040, 4'h1, 1'b0);
		pr(1'b1, 1'b0, 5'd6, 2'b10);
		pr(1'b1, 1'b0, 5'd2, 2'b01);
	endtask
	task automatic t_reset();
		check("clock_running", 32'h1, {31'h0, clock_running});
		expv = 32'h0;
		wr(4'h0, 32'h0, 4'hf, 1'b0);
	endtask
	task automatic t_setclr();
		expv = 32'h12;
		wr(4'h4, 32'h12, 4'hf, 1'b0);
		expv = 32'h16;
		wr(4'h4, 32'h14, 4'hf, 1'b1);
		expv = 32'h14;
		wr(4'h0, 32'h02, 4'hf, 1'b0);
		wr(4'h0, 32'h02, 4'hf, 1'b1);
		expv = 32'h34;
		wr(4'h4, 32'hffff_ffa0, 4'h1, 1'b0);
		expv = 32'h24;
		wr(4'h0, 32'hffff_0010, 4'h3, 1'b0);
		wr(4'h8, 32'h24, 4'hf, 1'b1);
	endtask
	task automatic t_guard();
		pr(1'b1, 1'b0, 5'd5, 2'b10);
		pr(1'b1, 1'b1, 5'd5, 2'b01);
		pr(1'b0, 1'b0, 5'd2, 2'b01);
		pr(1'b1, 1'b0, 5'd4, 2'b01);
	endtask
	task automatic t_gate();
		@(posedge sys_clk);
		#1 guard_bus_clock = 1'b0;
		repeat (3) @(posedge sys_clk);
		check("clock_running", 32'h0, {31'h0, clock_running});
		pr(1'b1, 1'b0, 5'd5, 2'b00);
		#1 guard_bus_clock = 1'b1;
		repeat (3) @(posedge sys_clk);
		pr(1'b1, 1'b0, 5'd2, 2'b10);
	endtask
	task automatic results();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	initial begin
		rst = 1'b1;
		guard_bus_clock = 1'b1;
		clk_en = 1'b1;
		repeat (4) @(posedge sys_clk);
		#1 rst = 1'b0;
		t_reset();
		t_setclr();
		t_guard();
		t_gate();
		t_freeze();
		t_rerst();
		results();
	end
	// Whole run needs about 100 cycles
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 600) begin
			err_total++;
			results();
		end
	end
endmodule
